/* File: inc/hpma_pkg.sv */
// package: constants and types for the host protected max address command block
package hpma_pkg;
   // register indices on the plain port
   localparam logic [3:0] REG_SUBCMD = 4'h1;
   localparam logic [3:0] REG_ERROR = 4'h1;
   localparam logic [3:0] REG_SECCNT = 4'h2;
   localparam logic [3:0] REG_ADDR_LOW = 4'h3;
   localparam logic [3:0] REG_ADDR_MID = 4'h4;
   localparam logic [3:0] REG_ADDR_HIGH = 4'h5;
   localparam logic [3:0] REG_DRVSEL = 4'h6;
   localparam logic [3:0] REG_OPCODE = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_IDENT_LO = 4'h9;
   localparam logic [3:0] REG_IDENT_HI = 4'hA;
   // opcodes and subcommands
   localparam logic [7:0] OP_SET_MAX = 8'hF9;
   localparam logic [7:0] OP_READ_NATIVE = 8'hF8;
   localparam logic [7:0] SUB_ADDRESS = 8'h00;
   localparam logic [7:0] SUB_SET_PASSWORD = 8'h01;
   localparam logic [7:0] SUB_LOCK = 8'h02;
   localparam logic [7:0] SUB_UNLOCK = 8'h03;
   localparam logic [7:0] SUB_FREEZE = 8'h04;
   // status bits
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_FAULT = 5;
   localparam int ST_DREQ = 3;
   localparam int ST_ERR = 0;
   // error bits
   localparam int ER_ID_NOT_FOUND_BIT = 4;
   localparam int ER_COMMAND_ABORTED_BIT = 2;
   // device-select and sector-count fields, reset values
   localparam int DS_LBA = 6;
   localparam int SC_NONVOL = 0;
   localparam logic [7:0] DRVSEL_RESET = 8'hA0;
   localparam logic [7:0] STATUS_RESET = 8'h40;
   // password sector layout in 16-bit words
   localparam logic [7:0] PW_FIRST = 8'd1;
   localparam logic [7:0] PW_LAST = 8'd16;
   localparam logic [7:0] SECTOR_LAST = 8'd255;
   localparam int PW_WORDS = 16;

   typedef enum logic [1:0] {
      HPMA_IDLE = 2'b00,
      HPMA_DATA = 2'b01
   } hpma_state_t;

   typedef enum logic [1:0] {
      HPMA_UNLOCKED = 2'b00,
      HPMA_LOCKED = 2'b01,
      HPMA_FROZEN = 2'b11
   } hpma_lock_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } hpma_bus_t;

   typedef struct packed {
      logic [27:0] limit;
      logic busy;
   } hpma_media_t;
endpackage

/* File: hw/hpma_core.sv */
// host protected max address command interpreter
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module hpma_core
   import hpma_pkg::*;
#(
   parameter logic [27:0] NATIVE_MAX = 28'hFFFFFFF,
   parameter bit SUPPORTED = 1'b1,
   parameter bit SUPPORT_48 = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // power-on or hardware reset event (same clock)
   input wire logic hw_reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // media access check
   input wire logic [27:0] access_lba,
   input wire logic access_req,
   output logic access_reject,
   // state exported
   output logic [27:0] max_address,
   output logic [1:0] lock_state
);
   // a zero capacity leaves no address that a set could name
   generate
      if (NATIVE_MAX == 28'h0) begin : g_bad_native
         $error("NATIVE_MAX must be nonzero");
      end
   endgenerate

   // command sequencing
   hpma_state_t state;
   hpma_lock_t lock;
   logic after_native;
   // task-file registers as the host sees them
   logic [7:0] subcmd;
   logic [7:0] seccnt;
   logic [7:0] addr_low;
   logic [7:0] addr_mid;
   logic [7:0] addr_high;
   logic [7:0] drvsel;
   logic [7:0] status;
   logic [7:0] err;
   // protected area limits
   logic [27:0] cur_max;
   logic [27:0] kept_max;
   logic ext_set;
   logic [1:0] nonvol_count;
   // password sector transfer
   logic [7:0] word_idx;
   // held for a later unlock compare, which this block does not serve
   logic [15:0] password [PW_WORDS];
   // decode
   logic [27:0] req_max;
   logic cmd_wr;
   logic data_wr;
   logic is_address;
   logic addr_ok;
   logic addr_id_not_found_bit;
   logic [7:0] next_err;
   logic pw_start;
   logic pw_done;

   assign req_max = {drvsel[3:0], addr_high, addr_mid, addr_low};
   assign cmd_wr = reg_wr && reg_addr == REG_OPCODE && state == HPMA_IDLE && !status[ST_BUSY];
   assign data_wr = reg_wr && reg_addr == REG_DATA && state == HPMA_DATA;
   // any F9h right after read native is taken as an address set
   assign is_address = reg_wdata[7:0] == OP_SET_MAX && (subcmd == SUB_ADDRESS || after_native);
   assign addr_ok = SUPPORTED && req_max <= NATIVE_MAX && !ext_set && lock == HPMA_UNLOCKED
      && after_native && drvsel[DS_LBA];
   assign addr_id_not_found_bit = seccnt[SC_NONVOL] && nonvol_count != 2'd0;

   // read-native flag, cleared by every other command
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         after_native <= 1'b0;
      end else if (cmd_wr) begin
         after_native <= reg_wdata[7:0] == OP_READ_NATIVE && SUPPORTED;
      end
   end

   // task-file writes from host and command results
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         subcmd <= 8'h00;
         seccnt <= 8'h00;
         addr_low <= 8'h00;
         addr_mid <= 8'h00;
         addr_high <= 8'h00;
         drvsel <= DRVSEL_RESET;
      end else if (cmd_wr && reg_wdata[7:0] == OP_READ_NATIVE) begin
         {drvsel[3:0], addr_high, addr_mid, addr_low} <= NATIVE_MAX;
      end else if (cmd_wr && is_address && addr_ok && !addr_id_not_found_bit) begin
         {drvsel[3:0], addr_high, addr_mid, addr_low} <= req_max;
      end else if (reg_wr && !status[ST_BUSY] && state == HPMA_IDLE) begin
         unique case (reg_addr)
            REG_SUBCMD: subcmd <= reg_wdata[7:0];
            REG_SECCNT: seccnt <= reg_wdata[7:0];
            REG_ADDR_LOW: addr_low <= reg_wdata[7:0];
            REG_ADDR_MID: addr_mid <= reg_wdata[7:0];
            REG_ADDR_HIGH: addr_high <= reg_wdata[7:0];
            REG_DRVSEL: drvsel <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // error outcome of an opcode write, decided in the write cycle
   always_comb begin
      next_err = 8'h00;
      if (reg_wdata[7:0] == OP_SET_MAX) begin
         if (is_address) begin
            if (!addr_ok) begin
               next_err[ER_COMMAND_ABORTED_BIT] = 1'b1;
            end else if (addr_id_not_found_bit) begin
               next_err[ER_ID_NOT_FOUND_BIT] = 1'b1;
            end
         end else if (subcmd == SUB_SET_PASSWORD) begin
            if (!SUPPORTED || lock != HPMA_UNLOCKED) begin
               next_err[ER_COMMAND_ABORTED_BIT] = 1'b1;
            end
         end else if (subcmd == SUB_LOCK) begin
            // once locked, every further set max command, unlock included, aborts
            if (!SUPPORTED || lock != HPMA_UNLOCKED) begin
               next_err[ER_COMMAND_ABORTED_BIT] = 1'b1;
            end
         end else begin
            // unlock, freeze and reserved values are not served here
            next_err[ER_COMMAND_ABORTED_BIT] = 1'b1;
         end
      end else if (reg_wdata[7:0] != OP_READ_NATIVE || !SUPPORTED) begin
         next_err[ER_COMMAND_ABORTED_BIT] = 1'b1;
      end
   end

   assign pw_start = cmd_wr && reg_wdata[7:0] == OP_SET_MAX && !is_address && subcmd == SUB_SET_PASSWORD
      && next_err == 8'h00;
   assign pw_done = data_wr && word_idx == SECTOR_LAST;

   // error register, rewritten by every command
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err <= 8'h00;
      end else if (cmd_wr) begin
         err <= next_err;
      end
   end

   // status register: non-data commands complete in the write cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status <= STATUS_RESET;
      end else if (cmd_wr) begin
         status <= STATUS_RESET;
         status[ST_ERR] <= next_err != 8'h00;
         status[ST_DREQ] <= pw_start;
      end else if (pw_done) begin
         status <= STATUS_RESET;
      end
   end

   // transfer phase of the password sector
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= HPMA_IDLE;
      end else if (pw_start) begin
         state <= HPMA_DATA;
      end else if (pw_done) begin
         state <= HPMA_IDLE;
      end
   end

   // word position inside the sector; wraps to zero after the last word
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         word_idx <= 8'h00;
      end else if (pw_start) begin
         word_idx <= 8'h00;
      end else if (data_wr) begin
         word_idx <= word_idx + 8'd1;
      end
   end

   // password store, cleared only by rst; hw_reset leaves it in place
   generate
      for (genvar w = 0; w < PW_WORDS; w++) begin : g_pw
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               password[w] <= 16'h0000;
            end else if (data_wr && word_idx == PW_FIRST + 8'(w)) begin
               password[w] <= reg_wdata;
            end
         end
      end
   endgenerate

   // lock state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lock <= HPMA_UNLOCKED;
      end else if (hw_reset) begin
         lock <= HPMA_UNLOCKED;
      end else if (cmd_wr && reg_wdata[7:0] == OP_SET_MAX && !is_address && next_err == 8'h00) begin
         if (subcmd == SUB_SET_PASSWORD) begin
            lock <= HPMA_UNLOCKED;
         end else if (subcmd == SUB_LOCK) begin
            lock <= HPMA_LOCKED;
         end
      end
   end

   // max address, non-volatile copy, counter, ext marker
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cur_max <= NATIVE_MAX;
         kept_max <= NATIVE_MAX;
         nonvol_count <= 2'd0;
         ext_set <= 1'b0;
      end else if (hw_reset) begin
         cur_max <= kept_max;
         nonvol_count <= 2'd0;
      end else if (cmd_wr && is_address && addr_ok && !addr_id_not_found_bit) begin
         cur_max <= req_max;
         if (seccnt[SC_NONVOL]) begin
            kept_max <= req_max;
            nonvol_count <= 2'd1;
         end
      end
   end

   // media access limit check
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         access_reject <= 1'b0;
      end else begin
         access_reject <= access_req && access_lba > cur_max;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_ERROR: reg_rdata <= {8'h00, err};
            REG_SECCNT: reg_rdata <= {8'h00, seccnt};
            REG_ADDR_LOW: reg_rdata <= {8'h00, addr_low};
            REG_ADDR_MID: reg_rdata <= {8'h00, addr_mid};
            REG_ADDR_HIGH: reg_rdata <= {8'h00, addr_high};
            REG_DRVSEL: reg_rdata <= {8'h00, drvsel};
            REG_STATUS: reg_rdata <= {8'h00, status};
            REG_CTRL: reg_rdata <= {13'h0000, ext_set, lock};
            // identify words 61:60 and 103:100 carry max plus one
            REG_IDENT_LO: reg_rdata <= 16'(cur_max + 28'd1);
            REG_IDENT_HI: reg_rdata <= {4'h0, 12'((cur_max + 28'd1) >> 16)};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   assign max_address = cur_max;
   assign lock_state = lock;
endmodule

/* File: tb/hpma_core_asserts.sv */
// checker: port-level properties of the max address block
`timescale 1ns/1ps
module hpma_core_asserts
   import hpma_pkg::*;
#(
   parameter logic [27:0] NATIVE_MAX = 28'hFFFFFFF
) (
   // watched ports
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hw_reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [27:0] access_lba,
   input wire logic access_req,
   input wire logic access_reject,
   input wire logic [27:0] max_address,
   input wire logic [1:0] lock_state
);
   logic native_last;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // hw_reset left out on purpose: after_native in the core is not cleared there either
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         native_last <= 1'b0;
      end else if (reg_wr && reg_addr == REG_OPCODE) begin
         native_last <= reg_wdata[7:0] == OP_READ_NATIVE;
      end
   end
   sequence s_set; reg_wr && reg_addr == REG_OPCODE && reg_wdata[7:0] == OP_SET_MAX; endsequence
   property p_status; reg_rd && reg_addr == REG_STATUS |=> !reg_rdata[ST_BUSY] && reg_rdata[ST_READY]; endproperty
   a_status: assert property (p_status) else $error("status busy or not ready");
   property p_no_prefix; s_set ##0 (!native_last) |=> $stable(max_address); endproperty
   a_no_prefix: assert property (p_no_prefix) else $error("max moved without prefix");
   property p_locked; s_set ##0 (lock_state != HPMA_UNLOCKED) |=> $stable(max_address); endproperty
   a_locked: assert property (p_locked) else $error("max moved while locked");
   property p_cap; max_address <= NATIVE_MAX; endproperty
   a_cap: assert property (p_cap) else $error("max above capacity");
   property p_hold; !(reg_wr && reg_addr == REG_OPCODE) && !hw_reset |=> $stable(max_address); endproperty
   a_hold: assert property (p_hold) else $error("max moved without command");
   property p_rej; access_req && access_lba > max_address |=> access_reject; endproperty
   a_rej: assert property (p_rej) else $error("access above max passed");
   property p_pass; access_req && access_lba <= max_address |=> !access_reject; endproperty
   a_pass: assert property (p_pass) else $error("access in range rejected");
   property p_hw; hw_reset |=> lock_state == HPMA_UNLOCKED; endproperty
   a_hw: assert property (p_hw) else $error("lock kept over hardware reset");
endmodule

bind hpma_core hpma_core_asserts #(.NATIVE_MAX(NATIVE_MAX)) chk (.sys_clk(sys_clk), .rst(rst), .hw_reset(hw_reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .access_lba(access_lba), .access_req(access_req), .access_reject(access_reject), .max_address(max_address),
   .lock_state(lock_state));

/* File: tb/hpma_host.sv */
// host adapter model: task-file register cycles and command sequences
`timescale 1ns/1ps
module hpma_host
   import hpma_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register port toward the device
   output logic [3:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // pre puts a read-native directly ahead of the command
   task automatic cmd(input logic pre, input logic [7:0] f, input logic [7:0] sc, input logic [27:0] a,
      input logic [7:0] op);
      if (pre) wr(REG_OPCODE, {8'h00, OP_READ_NATIVE});
      wr(REG_SUBCMD, {8'h00, f});
      wr(REG_SECCNT, {8'h00, sc});
      wr(REG_ADDR_LOW, {8'h00, a[7:0]});
      wr(REG_ADDR_MID, {8'h00, a[15:8]});
      wr(REG_ADDR_HIGH, {8'h00, a[23:16]});
      wr(REG_DRVSEL, {8'h00, 4'hE, a[27:24]});
      wr(REG_OPCODE, {8'h00, op});
   endtask
   task automatic sector(input logic [7:0] s);
      for (int i = 0; i < 256; i++) wr(REG_DATA, {s, i[7:0]});
   endtask
endmodule

/* File: tb/test_host_protected_max_address.sv */
// testbench: max address command scenarios
`timescale 1ns/1ps
module test_host_protected_max_address;
   import hpma_pkg::*;
   localparam logic [27:0] NMAX = 28'h1FFFFFF;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hw_reset = 1'b0;
   logic access_req = 1'b0;
   logic [27:0] access_lba = 28'h0;
   logic access_reject, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [27:0] max_address;
   logic [1:0] lock_state;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   always #2 sys_clk = ~sys_clk;
   hpma_core #(.NATIVE_MAX(NMAX)) uut (.sys_clk(sys_clk), .rst(rst), .hw_reset(hw_reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .access_lba(access_lba),
      .access_req(access_req), .access_reject(access_reject), .max_address(max_address), .lock_state(lock_state));
   hpma_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic regs(input logic [15:0] st, input logic [15:0] er);
      logic [15:0] d;
      host.rd(REG_STATUS, d);
      chk(d, st, "status");
      host.rd(REG_ERROR, d);
      chk(d, er, "error");
   endtask
   task automatic pulse_hw;
      @(posedge sys_clk);
      hw_reset <= 1'b1;
      @(posedge sys_clk);
      hw_reset <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic probe(input logic [27:0] a, input logic exp);
      @(posedge sys_clk);
      access_lba <= a;
      access_req <= 1'b1;
      @(posedge sys_clk);
      access_req <= 1'b0;
      #1;
      chk(access_reject, exp, "reject");
   endtask
   task automatic t_set;
      logic [15:0] d;
      host.cmd(1'b0, SUB_ADDRESS, 8'h01, 28'h0000100, OP_SET_MAX);
      regs(16'h0041, 16'h0004);
      host.cmd(1'b1, SUB_ADDRESS, 8'h00, NMAX + 28'h1, OP_SET_MAX);
      regs(16'h0041, 16'h0004);
      host.cmd(1'b1, SUB_ADDRESS, 8'h01, 28'h1234567, OP_SET_MAX);
      regs(16'h0040, 16'h0000);
      host.rd(REG_ADDR_LOW, d);
      chk(d, 16'h0067, "low");
      host.rd(REG_ADDR_HIGH, d);
      chk(d, 16'h0023, "high");
      host.rd(REG_DRVSEL, d);
      chk(d[3:0], 4'h1, "top");
      host.rd(REG_IDENT_LO, d);
      chk(d, 16'h4568, "id lo");
      host.rd(REG_IDENT_HI, d);
      chk(d, 16'h0123, "id hi");
      probe(28'h1234568, 1'b1);
      probe(28'h1234567, 1'b0);
      host.cmd(1'b1, SUB_ADDRESS, 8'h01, 28'h0000100, OP_SET_MAX);
      host.rd(REG_ERROR, d);
      chk(d[ER_ID_NOT_FOUND_BIT], 1'b1, "second");
      chk(max_address, 28'h1234567, "max");
      $display("address set done");
   endtask
   task automatic t_vol;
      pulse_hw();
      host.cmd(1'b1, SUB_ADDRESS, 8'h01, 28'h0000300, OP_SET_MAX);
      regs(16'h0040, 16'h0000);
      host.cmd(1'b1, SUB_SET_PASSWORD, 8'h00, 28'h0000200, OP_SET_MAX);
      regs(16'h0040, 16'h0000);
      chk(max_address, 28'h0000200, "as address");
      pulse_hw();
      chk(max_address, 28'h0000300, "revert");
      $display("volatile done");
   endtask
   task automatic t_lock;
      logic [15:0] d;
      host.cmd(1'b0, SUB_SET_PASSWORD, 8'h00, 28'h0, OP_SET_MAX);
      host.rd(REG_STATUS, d);
      chk(d[ST_DREQ], 1'b1, "drq");
      host.sector(8'h5A);
      regs(16'h0040, 16'h0000);
      host.cmd(1'b0, SUB_LOCK, 8'h00, 28'h0, OP_SET_MAX);
      regs(16'h0040, 16'h0000);
      chk(lock_state, HPMA_LOCKED, "locked");
      for (int f = 0; f < 6; f++) begin
         host.cmd(f == 0, f[7:0], 8'h00, 28'h0000050, OP_SET_MAX);
         regs(16'h0041, 16'h0004);
      end
      pulse_hw();
      chk(lock_state, HPMA_UNLOCKED, "unlock");
      $display("lock done");
   endtask
   task automatic tally_and_finish;
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      regs(STATUS_RESET, 16'h0000);
      chk(max_address, NMAX, "native");
      t_set();
      t_vol();
      t_lock();
      tally_and_finish();
   end
endmodule
